// File: hw/mcv_map.svh
`ifndef MCV_MAP_SVH
`define MCV_MAP_SVH
`define MCV_DATA_OFFSET 8'h55
`define MCV_IO_OFFSET 6'h35
`define MCV_IO_BASE 8'h20
`define MCV_EXT_IO_BASE 8'h60
`define MCV_RESET_VALUE 8'h00
`define MCV_BIT_DEBUG_DIS 7
`define MCV_BIT_PULLUP_DIS 4
`define MCV_BIT_VEC_SEL 1
`define MCV_BIT_VEC_CHG 0
`define MCV_WRITE_MASK 8'h93
`define MCV_TIMED_CYCLES 3'h4
`endif

// File: hw/mcv_pkg.sv
package mcv_pkg;
	typedef logic [7:0] mcv_byte_t;
	typedef logic [2:0] mcv_count_t;
	typedef logic [15:0] mcv_addr_t;
endpackage : mcv_pkg

// File: hw/mcv_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "mcv_map.svh"
module mcv_timer
	import mcv_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic cancel,
	output logic active
);
	mcv_count_t count_q;
	mcv_count_t count_d;
	wire running = (count_q != 3'h0);
	// Start restarts the window; cancel wins over an expiring count
	assign count_d = cancel ? 3'h0 : start ? `MCV_TIMED_CYCLES : running ? count_q - 3'h1 : 3'h0;
	assign active = running;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) count_q <= 3'h0;
		else count_q <= count_d;
	end
endmodule : mcv_timer
`default_nettype wire

// File: hw/mcv_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "mcv_map.svh"
module mcv_control
	import mcv_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic io_we,
	input wire logic io_re,
	input wire logic [5:0] io_addr,
	input wire logic ds_we,
	input wire logic ds_re,
	input wire logic [15:0] ds_addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic rsel,
	input wire logic instr_done,
	input wire logic [1:0] boot_size_fuses,
	input wire logic app_boot_lock_bit,
	input wire logic boot_section_lock_bit,
	input wire logic exec_in_boot,
	input wire logic debug_port_enable_fuse,
	input wire logic [5:0] vector_index,
	output logic [16:0] vector_address,
	output logic irq_block,
	output logic debug_port_enabled,
	output logic pullup_disable,
	output logic vector_table_select
);
	// I/O window covers only 0x20..0x5f; extended space never matches it
	wire io_hit = (io_addr == `MCV_IO_OFFSET);
	wire ds_hit = (ds_addr == {8'h00, `MCV_DATA_OFFSET});
	wire wr = (io_we & io_hit) | (ds_we & ds_hit);
	wire rd = (io_re & io_hit) | (ds_re & ds_hit);
	mcv_byte_t wval;
	assign wval = wdata & `MCV_WRITE_MASK;
	logic sel_q, sel_d, dbg_q, dbg_d, pud_q, post_q, post_d;
	logic dbg_pend_q, dbg_val_q;
	wire chg_active;
	wire dbg_active;
	wire chg_set = wr & wval[`MCV_BIT_VEC_CHG] & ~chg_active;
	// Select write only legal with enable low during the window
	wire sel_write = wr & chg_active & ~wval[`MCV_BIT_VEC_CHG];
	mcv_timer u_chg (
		.clk(clk),
		.reset(reset),
		.start(chg_set),
		.cancel(sel_write),
		.active(chg_active)
	);
	wire dbg_w = wr & (wval[`MCV_BIT_DEBUG_DIS] != dbg_q);
	wire dbg_commit = dbg_w & dbg_pend_q & dbg_active & (dbg_val_q == wval[`MCV_BIT_DEBUG_DIS]);
	mcv_timer u_dbg (
		.clk(clk),
		.reset(reset),
		.start(dbg_w & ~dbg_commit),
		.cancel(dbg_commit),
		.active(dbg_active)
	);
	assign sel_d = sel_write ? wval[`MCV_BIT_VEC_SEL] : sel_q;
	assign dbg_d = dbg_commit ? wval[`MCV_BIT_DEBUG_DIS] : dbg_q;
	// Hold mask through the instruction after the select write
	assign post_d = sel_write ? 1'b1 : (instr_done ? 1'b0 : post_q);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sel_q <= 1'b0;
			dbg_q <= 1'b0;
			pud_q <= 1'b0;
			post_q <= 1'b0;
			dbg_pend_q <= 1'b0;
			dbg_val_q <= 1'b0;
		end else begin
			sel_q <= sel_d;
			dbg_q <= dbg_d;
			if (wr) pud_q <= wval[`MCV_BIT_PULLUP_DIS];
			post_q <= post_d;
			dbg_pend_q <= (dbg_w & ~dbg_commit) | (dbg_pend_q & dbg_active & ~dbg_commit);
			if (dbg_w) dbg_val_q <= wval[`MCV_BIT_DEBUG_DIS];
		end
	end
	// Boot start from fuses: 4K/2K/1K/512 words below top of flash
	logic [16:0] boot_start;
	always_comb begin
		unique case (boot_size_fuses)
			2'b00: boot_start = 17'h1f000;
			2'b01: boot_start = 17'h1f800;
			2'b10: boot_start = 17'h1fc00;
			2'b11: boot_start = 17'h1fe00;
		endcase
	end
	wire [16:0] table_addr = {10'h000, vector_index, 1'b0};
	assign vector_address = sel_q ? boot_start + table_addr : table_addr;
	// Mask only gates dispatch; status register flag is not touched here
	wire lock_block = (sel_q & app_boot_lock_bit & ~exec_in_boot) | (~sel_q & boot_section_lock_bit & exec_in_boot);
	assign irq_block = chg_active | post_q | lock_block;
	assign debug_port_enabled = debug_port_enable_fuse & ~dbg_q;
	assign pullup_disable = pud_q;
	assign vector_table_select = sel_q;
	mcv_byte_t rd_val;
	assign rd_val = {dbg_q, 2'b00, pud_q, 2'b00, sel_q, chg_active};
	assign rsel = rd;
	assign rdata = rd ? rd_val : 8'h00;
endmodule : mcv_control
`default_nettype wire

// File: bench/mcv_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module mcv_chk (input wire logic clk, reset, io_we, io_re, ds_we, ds_re, rsel, irq_block, debug_port_enabled,
	input wire logic debug_port_enable_fuse, pullup_disable, vector_table_select, app_boot_lock_bit,
	input wire logic boot_section_lock_bit, exec_in_boot, input wire logic [5:0] io_addr, vector_index,
	input wire logic [15:0] ds_addr, input wire logic [7:0] wdata, rdata, input wire logic [1:0] boot_size_fuses,
	input wire logic [16:0] vector_address);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire hit_w = io_we && io_addr == 6'h35;
	sequence chg_wr; hit_w && wdata[0] && !irq_block; endsequence
	pud_a: assert property (hit_w |=> pullup_disable == $past(wdata[4])) else $error("pud");
	sel_a: assert property (chg_wr ##1 !(io_we || ds_we) ##1 (hit_w && !wdata[0])
		|=> vector_table_select == $past(wdata[1])) else $error("select");
	rsel_a: assert property (rsel == (io_re && io_addr == 6'h35 || ds_re && ds_addr == 16'h0055))
		else $error("decode");
	zero_a: assert property (rdata[6:5] == 2'h0 && rdata[3:2] == 2'h0 && (rsel || rdata == 8'h00))
		else $error("bits");
	dbg_a: assert property (debug_port_enabled |-> debug_port_enable_fuse) else $error("dbg");
	vec_a: assert property (vector_address == {10'h0, vector_index, 1'b0}
		+ (vector_table_select ? 17'h20000 - (17'h1000 >> boot_size_fuses) : 17'h0)) else $error("vec");
	lock_a: assert property ((vector_table_select ? app_boot_lock_bit && !exec_in_boot
		: boot_section_lock_bit && exec_in_boot) |-> irq_block) else $error("lock");
	rel_a: assert property (chg_wr ##1 !(io_we || ds_we || app_boot_lock_bit || boot_section_lock_bit)[*6]
		|-> !irq_block) else $error("mask");
endmodule : mcv_chk
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk = 0, reset = 1, io_we = 0, io_re = 0, ds_we = 0, ds_re = 1, instr_done = 0, exec_in_boot = 0;
	logic app_boot_lock_bit = 0, boot_section_lock_bit = 0, debug_port_enable_fuse = 1, rsel, irq_block;
	logic debug_port_enabled, pullup_disable, vector_table_select;
	logic [5:0] io_addr = 6'h35, vector_index = 6'h03;
	logic [15:0] ds_addr = 16'h0055;
	logic [7:0] wdata = 8'h00, rdata;
	logic [1:0] boot_size_fuses = 2'h1;
	logic [16:0] vector_address; int err_total = 0, n_checks = 0;
	mcv_control u_dut (.*);
	always #12.5 clk = ~clk;
	task automatic chk(input logic [16:0] s, e);
		n_checks++;
		err_total += (s !== e);
		if (s !== e) $display("MISMATCH %0t got %h exp %h", $time, s, e);
	endtask : chk
	task automatic wr(input logic [7:0] d, input logic ds = 1'b0);
		@(posedge clk) {io_we, ds_we, wdata} <= {~ds, ds, d};
		@(posedge clk) {io_we, ds_we} <= 2'b00;
	endtask : wr
	task automatic stop_test(input int late);
		err_total += late;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	initial #20us stop_test(1);
	initial begin
		repeat (16) @(posedge clk);
		reset <= 0;
		#1 chk(rdata, 8'h00);
		wr(8'h11);
		wr(8'h12);
		#1 chk(rdata, 8'h12);
		chk(irq_block, 1'h1);
		{instr_done, boot_size_fuses} <= 3'h7;
		@(posedge clk) instr_done <= 0;
		@(posedge clk) #1 chk(irq_block, 1'h0);
		chk(vector_address, 17'h1fe06);
		chk(vector_table_select, 1'h1);
		wr(8'h92);
		wr(8'h92);
		#1 chk(rdata, 8'h92);
		chk(debug_port_enabled, 1'h0);
		wr(8'h12);
		#1 chk(rdata, 8'h92);
		wr(8'h93);
		#1 chk(irq_block, 1'h1);
		repeat (6) @(posedge clk);
		{app_boot_lock_bit, exec_in_boot} <= 2'h2;
		@(posedge clk) #1 chk(irq_block, 1'h1);
		wr(8'h80, 1'b1);
		#1 chk(rdata, 8'h82);
		chk(pullup_disable, 1'h0);
		$display("test sequence done");
		stop_test(0);
	end
endmodule : testbench
bind mcv_control mcv_chk u_chk (.*);
`default_nettype wire
